// *** dv/fault_simulation_sequencer_tb_top.sv ***
`timescale 1ns/1ps
module fault_simulation_sequencer_tb_top;
    import fss_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, sim_freq, gq;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, sim_active, prot_reset, freeze, trip;
    logic [1:0] bresp, rresp, mvt, vt = 2'h2;
    logic blk1 = 1'b0, blk2 = 1'b0, fpost = 1'b0, trig = 1'b0, fault_on = 1'b1, trip_req;
    logic [15:0] ia = 16'h0, ib = 16'h0, ic = 16'h0;
    logic [2:0] code, gidx = 3'h2;
    logic [17:0] code_log;
    int num_errors = 0, total_checks = 0;
    // design and far side
    fss_top #(.TICK_CYC(4), .RESET_MS(3), .HOLD_MS(5)) fss_top_inst (.aclk(aclk),
        .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .external_block_one(blk1), .external_block_two(blk2), .external_force_post(fpost),
        .external_sim_trigger(trig), .phase_current_a(ia), .phase_current_b(ib),
        .phase_current_c(ic), .vt_connection(vt), .prot_trip_request(trip_req),
        .gen_quant_idx(gidx), .sim_state_code(code), .sim_active(sim_active),
        .prot_reset(prot_reset), .energy_freeze(freeze), .breaker_trip_command(trip),
        .meas_vt_connection(mvt), .sim_freq(sim_freq), .gen_quant_data(gq), .irq(irq));
    fss_partner fss_partner_inst (.aclk(aclk), .aresetn(aresetn), .sim_state_code(code),
        .prot_reset(prot_reset), .fault_on(fault_on), .prot_trip_request(trip_req),
        .code_log(code_log));
    // 250 MHz clock
    always #2 aclk = ~aclk;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // axi4-lite write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            ad = ad | awready;
            wd = wd | wready;
        end while (!(ad && wd));
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
        chk("bresp", 32'h0, 32'(bresp));
    endtask
    // axi4-lite read with expected data and response
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
        chk("rdata", e, rdata);
        chk("rresp", 32'(er), 32'(rresp));
    endtask
    // bounded wait for a state code
    task automatic wait_code(input logic [2:0] c);
        int n;
        n = 0;
        while (code !== c && n < 4000) begin
            @(posedge aclk);
            n++;
        end
        chk("state code", 32'(c), 32'(code));
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        give_verdict();
    end
    // test sequence
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFF_PRE_MS, 32'h000003E8, 2'h0);
        rd(OFF_STATUS, 32'h0, 2'h0);
        rd(8'h30, 32'h0, 2'h2);
        chk("sim freq", 32'h0000C3A0, sim_freq);
        wr(OFF_RATED_FREQ, 32'h0000EA60);
        repeat (2) @(posedge aclk);
        chk("sim freq", 32'h0000EAC0, sim_freq);
        for (int i = 0; i < 3; i++) wr(OFF_PRE_MS + 8'(4 * i), 32'h0000000A);
        for (int i = 0; i < 3; i++) wr(OFF_QUANT + 8'(32 * i + 8), 32'(i + 5));
        wr(OFF_IRQ_MASK, 32'h1);
        // cold full cycle with a second start while running
        wr(OFF_CTRL, 32'h1);
        wait_code(CODE_PRE);
        chk("freeze", 32'h1, 32'(freeze));
        chk("vt", 32'(VT_WYE), 32'(mvt));
        chk("trip", 32'h0, 32'(trip));
        chk("active", 32'h1, 32'(sim_active));
        @(posedge aclk);
        chk("quant", 32'h5, gq);
        wr(OFF_CTRL, 32'h1);
        wait_code(CODE_NORMAL);
        @(posedge aclk);
        chk("log", 32'({CODE_RESET, CODE_PRE, CODE_FAULT, CODE_POST, CODE_RESET,
            CODE_NORMAL}), 32'(code_log));
        chk("freeze", 32'h0, 32'(freeze));
        chk("irq", 32'h1, 32'(irq));
        wr(OFF_IRQ_STATUS, 32'h1);
        @(posedge aclk);
        chk("irq", 32'h0, 32'(irq));
        // hot run ended by manual stop
        wr(OFF_CTRL, 32'h5);
        wait_code(CODE_FAULT);
        chk("trip", 32'h1, 32'(trip));
        @(posedge aclk);
        chk("quant", 32'h6, gq);
        wr(OFF_CTRL, 32'h6);
        repeat (2) @(posedge aclk);
        chk("state code", 32'(CODE_NORMAL), 32'(code));
        // force to post-fault
        wr(OFF_CTRL, 32'h9);
        wait_code(CODE_PRE);
        fpost <= 1'b1;
        repeat (6) @(posedge aclk);
        chk("state code", 32'(CODE_POST), 32'(code));
        fpost <= 1'b0;
        wait_code(CODE_NORMAL);
        // external start, then blocking
        wr(OFF_CTRL, 32'h10);
        trig <= 1'b1;
        repeat (6) @(posedge aclk);
        chk("state code", 32'(CODE_RESET), 32'(code));
        trig <= 1'b0;
        blk1 <= 1'b1;
        wr(OFF_CTRL, 32'h30);
        wait_code(CODE_NORMAL);
        trig <= 1'b1;
        repeat (6) @(posedge aclk);
        chk("state code", 32'(CODE_NORMAL), 32'(code));
        rd(OFF_STATUS, 32'h8, 2'h0);
        trig <= 1'b0;
        blk1 <= 1'b0;
        blk2 <= 1'b1;
        repeat (4) @(posedge aclk);
        wr(OFF_CTRL, 32'h50);
        wr(OFF_CTRL, 32'h51);
        repeat (4) @(posedge aclk);
        chk("state code", 32'(CODE_NORMAL), 32'(code));
        blk2 <= 1'b0;
        // over-current abort and restart lockout
        wr(OFF_IRQ_STATUS, 32'hF);
        wr(OFF_CTRL, 32'h1);
        wait_code(CODE_PRE);
        ib <= 16'h0065;
        repeat (3) @(posedge aclk);
        chk("state code", 32'(CODE_NORMAL), 32'(code));
        ib <= 16'h0064;
        wr(OFF_CTRL, 32'h1);
        repeat (3) @(posedge aclk);
        chk("state code", 32'(CODE_NORMAL), 32'(code));
        rd(OFF_STATUS, 32'h10, 2'h0);
        rd(OFF_IRQ_STATUS, 32'hA, 2'h0);
        chk("irq", 32'h0, 32'(irq));
        repeat (30) @(posedge aclk);
        wr(OFF_CTRL, 32'h1);
        repeat (2) @(posedge aclk);
        chk("state code", 32'(CODE_RESET), 32'(code));
        chk("prot reset", 32'h1, 32'(prot_reset));
        wr(OFF_CTRL, 32'h2);
        wait_code(CODE_NORMAL);
        give_verdict();
    end
endmodule

// *** dv/fss_partner.sv ***
`timescale 1ns/1ps
// protection functions and event recorder seen from the sequencer
module fss_partner (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // sequencer side
    input wire logic [2:0] sim_state_code,
    input wire logic prot_reset,
    input wire logic fault_on,
    output logic prot_trip_request,
    output logic [17:0] code_log
);
    logic [2:0] last_code;
    // protection trips on an applied fault unless held in its reset stage
    always_ff @(posedge aclk) begin
        prot_trip_request <= aresetn && fault_on && !prot_reset;
    end
    // recorder shifts in every new state code
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_code <= 3'h0;
            code_log <= 18'h00000;
        end else if (sim_state_code != last_code) begin
            last_code <= sim_state_code;
            code_log <= {code_log[14:0], sim_state_code};
        end
    end
endmodule

// *** rtl/fss_pkg.sv ***
package fss_pkg;
    // clock and timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_TICK_US = 1000;
    localparam int TICK_CYC_DEF = T_TICK_US * 1000 / CLK_PERIOD_NS;
    localparam int T_RESET_MS = 100;
    localparam int T_HOLD_S = 5;
    localparam int HOLD_MS_DEF = T_HOLD_S * 1000;
    // current threshold 0.1 x nominal, frequency +0.16 %
    localparam int THR_NUM = 1;
    localparam int THR_DEN = 10;
    localparam int FREQ_NUM = 10016;
    localparam int FREQ_DEN = 10000;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_PRE_MS = 8'h08;
    localparam logic [7:0] OFF_FAULT_MS = 8'h0C;
    localparam logic [7:0] OFF_POST_MS = 8'h10;
    localparam logic [7:0] OFF_NOMINAL = 8'h14;
    localparam logic [7:0] OFF_RATED_FREQ = 8'h18;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h1C;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
    localparam logic [7:0] OFF_QUANT = 8'h40;
    localparam int QUANT_WORDS = 24;
    // ctrl fields
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_HOT = 2;
    localparam int CTRL_FP_ASSIGN = 3;
    localparam int CTRL_TRIG_ASSIGN = 4;
    localparam int CTRL_BLK1_ASSIGN = 5;
    localparam int CTRL_BLK2_ASSIGN = 6;
    // status fields
    localparam int ST_BLOCKED = 3;
    localparam int ST_LOCKOUT = 4;
    localparam int ST_OVER = 5;
    // interrupt bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ABORT = 1;
    localparam int IRQ_FORCED = 2;
    localparam int IRQ_REFUSED = 3;
    // reset values
    localparam logic [15:0] DUR_RST = 16'h03E8;
    localparam logic [15:0] NOMINAL_RST = 16'h03E8;
    localparam logic [31:0] FREQ_RST = 32'h0000C350;
    // state codes to recorders
    localparam logic [2:0] CODE_NORMAL = 3'h0;
    localparam logic [2:0] CODE_PRE = 3'h1;
    localparam logic [2:0] CODE_FAULT = 3'h2;
    localparam logic [2:0] CODE_POST = 3'h3;
    localparam logic [2:0] CODE_RESET = 3'h4;
    // voltage transformer connections
    localparam logic [1:0] VT_WYE = 2'h1;
    typedef enum logic [2:0] {S_IDLE, S_RST_IN, S_PRE, S_FAULT, S_POST, S_RST_OUT} fss_state_t;
endpackage

// *** rtl/fss_top.sv ***
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module fss_top
    import fss_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYC_DEF,
    parameter int RESET_MS = T_RESET_MS,
    parameter int HOLD_MS = HOLD_MS_DEF
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // external pins
    input wire logic external_block_one,
    input wire logic external_block_two,
    input wire logic external_force_post,
    input wire logic external_sim_trigger,
    // measurement and protection side
    input wire logic [15:0] phase_current_a,
    input wire logic [15:0] phase_current_b,
    input wire logic [15:0] phase_current_c,
    input wire logic [1:0] vt_connection,
    input wire logic prot_trip_request,
    input wire logic [2:0] gen_quant_idx,
    // outputs
    output logic [2:0] sim_state_code,
    output logic sim_active,
    output logic prot_reset,
    output logic energy_freeze,
    output logic breaker_trip_command,
    output logic [1:0] meas_vt_connection,
    output logic [31:0] sim_freq,
    output logic [31:0] gen_quant_data,
    output logic irq
);
    fss_state_t state_reg, state_next;
    logic [2:0] code_reg;
    logic [3:0] sync1_reg, sync2_reg, sync3_reg;
    logic [6:0] ctrl_reg;
    logic [15:0] pre_ms_reg, fault_ms_reg, post_ms_reg, nominal_reg, ms_cnt_reg, hold_cnt_reg;
    logic [31:0] freq_reg, tick_cnt_reg, sim_freq_reg, quant_data_reg;
    logic [31:0] quant_mem [QUANT_WORDS];
    logic [3:0] irq_st_reg, irq_mask_reg, ev;
    logic lockout_reg, freeze_reg, trip_reg, act_reg, prst_reg;
    logic [1:0] vt_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg, rdata_reg;
    logic [3:0] w_strb_reg;
    logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic wr_en, ms_tick, over, blocked, start_req, stop_req, force_rise, trig_rise;
    logic running, phase_done, start_ok, oc_abort;
    logic [15:0] thr, dur;
    logic [4:0] wq_idx, rq_idx, gq_idx;
    logic wq_hit, rq_hit;

    // byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // recorder code of each state
    function automatic logic [2:0] code_of(input fss_state_t s);
        unique case (s)
            S_IDLE: code_of = CODE_NORMAL;
            S_PRE: code_of = CODE_PRE;
            S_FAULT: code_of = CODE_FAULT;
            S_POST: code_of = CODE_POST;
            S_RST_IN, S_RST_OUT: code_of = CODE_RESET;
        endcase
    endfunction

    // pin synchronisers, third stage for edge detection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            sync3_reg <= 4'h0;
        end else begin
            sync1_reg <= {external_sim_trigger, external_force_post,
                          external_block_two, external_block_one};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // block, force and trigger only act when assigned
    assign blocked = (sync2_reg[0] && ctrl_reg[CTRL_BLK1_ASSIGN])
                   || (sync2_reg[1] && ctrl_reg[CTRL_BLK2_ASSIGN]);
    assign force_rise = ctrl_reg[CTRL_FP_ASSIGN] && sync2_reg[2] && !sync3_reg[2];
    assign trig_rise = ctrl_reg[CTRL_TRIG_ASSIGN] && sync2_reg[3] && !sync3_reg[3];
    assign thr = 16'((32'(nominal_reg) * THR_NUM) / THR_DEN);
    assign over = (phase_current_a > thr) || (phase_current_b > thr)
                || (phase_current_c > thr);
    assign running = (state_reg != S_IDLE);

    // axi write: address and data taken in either order
    assign wr_en = aw_full_reg && w_full_reg && !bvalid_reg;
    assign start_req = (wr_en && aw_addr_reg == OFF_CTRL && w_strb_reg[0]
                        && w_data_reg[CTRL_START]) || trig_rise;
    assign stop_req = wr_en && aw_addr_reg == OFF_CTRL && w_strb_reg[0]
                    && w_data_reg[CTRL_STOP];
    assign start_ok = !running && !blocked && !over && !lockout_reg;
    assign oc_abort = running && over;

    // millisecond tick
    assign ms_tick = (tick_cnt_reg == 32'(TICK_CYC - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_reg <= 32'h0;
        end else begin
            tick_cnt_reg <= ms_tick ? 32'h0 : tick_cnt_reg + 32'h1;
        end
    end

    // duration of the current stage
    always_comb begin
        unique case (state_reg)
            S_PRE: dur = pre_ms_reg;
            S_FAULT: dur = fault_ms_reg;
            S_POST: dur = post_ms_reg;
            default: dur = 16'(RESET_MS);
        endcase
    end
    assign phase_done = (ms_cnt_reg >= dur);

    // sequencer next state
    always_comb begin
        state_next = state_reg;
        if (stop_req || oc_abort || (running && blocked)) begin
            state_next = S_IDLE;
        end else begin
            unique case (state_reg)
                S_IDLE: if (start_req && start_ok) state_next = S_RST_IN;
                S_RST_IN: if (phase_done) state_next = S_PRE;
                S_PRE: if (force_rise) state_next = S_POST;
                       else if (phase_done) state_next = S_FAULT;
                S_FAULT: if (force_rise || phase_done) state_next = S_POST;
                S_POST: if (phase_done) state_next = S_RST_OUT;
                S_RST_OUT: if (phase_done) state_next = S_IDLE;
            endcase
        end
    end

    // state, code and stage timer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= S_IDLE;
            code_reg <= CODE_NORMAL;
            ms_cnt_reg <= 16'h0;
        end else begin
            state_reg <= state_next;
            code_reg <= code_of(state_next);
            if (state_next != state_reg) begin
                ms_cnt_reg <= 16'h0;
            end else if (ms_tick && !phase_done) begin
                ms_cnt_reg <= ms_cnt_reg + 16'h1;
            end
        end
    end

    // restart lockout after an over-current abort
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lockout_reg <= 1'b0;
            hold_cnt_reg <= 16'h0;
        end else if (oc_abort) begin
            lockout_reg <= 1'b1;
            hold_cnt_reg <= 16'h0;
        end else if (over) begin
            hold_cnt_reg <= 16'h0;
        end else if (lockout_reg && ms_tick) begin
            if (hold_cnt_reg >= 16'(HOLD_MS - 1)) begin
                lockout_reg <= 1'b0;
                hold_cnt_reg <= 16'h0;
            end else begin
                hold_cnt_reg <= hold_cnt_reg + 16'h1;
            end
        end
    end

    // outputs toward protection, counters and generator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            act_reg <= 1'b0;
            prst_reg <= 1'b0;
            freeze_reg <= 1'b0;
            trip_reg <= 1'b0;
            vt_reg <= 2'h0;
            sim_freq_reg <= 32'h0;
        end else begin
            act_reg <= (state_next != S_IDLE);
            prst_reg <= (state_next == S_RST_IN) || (state_next == S_RST_OUT);
            freeze_reg <= (state_next != S_IDLE);
            trip_reg <= prot_trip_request
                      && !(running && !ctrl_reg[CTRL_HOT]);
            vt_reg <= running ? VT_WYE : vt_connection;
            sim_freq_reg <= 32'((64'(freq_reg) * FREQ_NUM) / FREQ_DEN);
        end
    end

    // quantity set of the active phase
    assign gq_idx = (state_reg == S_FAULT) ? 5'(8 + gen_quant_idx)
                  : (state_reg == S_POST) ? 5'(16 + gen_quant_idx) : 5'(gen_quant_idx);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            quant_data_reg <= 32'h0;
        end else begin
            quant_data_reg <= (state_reg == S_PRE || state_reg == S_FAULT
                               || state_reg == S_POST) ? quant_mem[gq_idx] : 32'h0;
        end
    end

    // interrupt events
    assign ev[IRQ_DONE] = (state_reg == S_RST_OUT) && (state_next == S_IDLE) && phase_done;
    assign ev[IRQ_ABORT] = oc_abort;
    assign ev[IRQ_FORCED] = (state_reg == S_PRE || state_reg == S_FAULT)
                          && (state_next == S_POST) && force_rise;
    assign ev[IRQ_REFUSED] = start_req && !start_ok && !running;

    // sticky status, set wins over write-one-clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_st_reg <= 4'h0;
        end else if (wr_en && aw_addr_reg == OFF_IRQ_STATUS && w_strb_reg[0]) begin
            irq_st_reg <= (irq_st_reg & ~w_data_reg[3:0]) | ev;
        end else begin
            irq_st_reg <= irq_st_reg | ev;
        end
    end

    // write channel capture and response
    assign wq_idx = 5'((aw_addr_reg - OFF_QUANT) >> 2);
    // full 8-bit window test, the 5-bit index alone would alias high offsets
    assign wq_hit = (aw_addr_reg >= OFF_QUANT)
                  && (aw_addr_reg < OFF_QUANT + 8'(4 * QUANT_WORDS));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 8'h0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
        end else begin
            if (s_axi_awvalid && !aw_full_reg) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && !w_full_reg) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_en) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= (aw_addr_reg <= OFF_IRQ_MASK
                              || wq_hit)
                             ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= 7'h0;
            pre_ms_reg <= DUR_RST;
            fault_ms_reg <= DUR_RST;
            post_ms_reg <= DUR_RST;
            nominal_reg <= NOMINAL_RST;
            freq_reg <= FREQ_RST;
            irq_mask_reg <= 4'h0;
        end else if (wr_en) begin
            unique case (aw_addr_reg)
                OFF_CTRL: ctrl_reg <= 7'(merge(32'(ctrl_reg), w_data_reg, w_strb_reg)
                                         & 32'h7C);
                OFF_PRE_MS: pre_ms_reg <= 16'(merge(32'(pre_ms_reg), w_data_reg, w_strb_reg));
                OFF_FAULT_MS: fault_ms_reg <= 16'(merge(32'(fault_ms_reg), w_data_reg,
                                                        w_strb_reg));
                OFF_POST_MS: post_ms_reg <= 16'(merge(32'(post_ms_reg), w_data_reg, w_strb_reg));
                OFF_NOMINAL: nominal_reg <= 16'(merge(32'(nominal_reg), w_data_reg, w_strb_reg));
                OFF_RATED_FREQ: freq_reg <= merge(freq_reg, w_data_reg, w_strb_reg);
                OFF_IRQ_MASK: irq_mask_reg <= 4'(merge(32'(irq_mask_reg), w_data_reg,
                                                       w_strb_reg));
                default: ;
            endcase
        end
    end

    // simulated quantity store, three phases of eight words
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < QUANT_WORDS; i++) begin
                quant_mem[i] <= 32'h0;
            end
        end else if (wr_en && wq_hit) begin
            quant_mem[wq_idx] <= merge(quant_mem[wq_idx], w_data_reg, w_strb_reg);
        end
    end

    // read channel
    assign rq_idx = 5'((s_axi_araddr - OFF_QUANT) >> 2);
    assign rq_hit = (s_axi_araddr >= OFF_QUANT)
                  && (s_axi_araddr < OFF_QUANT + 8'(4 * QUANT_WORDS));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= 2'h0;
        end else if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= 2'h0;
            unique case ({s_axi_araddr[7:2], 2'h0})
                OFF_CTRL: rdata_reg <= 32'(ctrl_reg);
                OFF_STATUS: rdata_reg <= 32'({over, lockout_reg, blocked, code_reg});
                OFF_PRE_MS: rdata_reg <= 32'(pre_ms_reg);
                OFF_FAULT_MS: rdata_reg <= 32'(fault_ms_reg);
                OFF_POST_MS: rdata_reg <= 32'(post_ms_reg);
                OFF_NOMINAL: rdata_reg <= 32'(nominal_reg);
                OFF_RATED_FREQ: rdata_reg <= freq_reg;
                OFF_IRQ_STATUS: rdata_reg <= 32'(irq_st_reg);
                OFF_IRQ_MASK: rdata_reg <= 32'(irq_mask_reg);
                default: begin
                    if (rq_hit) begin
                        rdata_reg <= quant_mem[rq_idx];
                    end else begin
                        rdata_reg <= 32'h0;
                        rresp_reg <= 2'h2;
                    end
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // port drive
    assign s_axi_awready = !aw_full_reg;
    assign s_axi_wready = !w_full_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign sim_state_code = code_reg;
    assign sim_active = act_reg;
    assign prot_reset = prst_reg;
    assign energy_freeze = freeze_reg;
    assign breaker_trip_command = trip_reg;
    assign meas_vt_connection = vt_reg;
    assign sim_freq = sim_freq_reg;
    assign gen_quant_data = quant_data_reg;
    assign irq = |(irq_st_reg & irq_mask_reg);

    // checks
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_force_in_run;
        (code_reg == CODE_PRE || code_reg == CODE_FAULT) ##0 force_rise
            ##0 !(stop_req || over || blocked);
    endsequence
    sequence s_cold_trip;
        running && !ctrl_reg[CTRL_HOT] && prot_trip_request;
    endsequence
    phase_order_a: assert property ($changed(code_reg) && $past(code_reg) == CODE_PRE
        |-> code_reg == CODE_FAULT || code_reg == CODE_POST || code_reg == CODE_NORMAL)
        else $error("pre-fault left to a wrong stage");
    pre_entry_a: assert property ($rose(code_reg == CODE_PRE) |-> $past(code_reg) == CODE_RESET
        && $past(prot_reset))
        else $error("pre-fault entered without reset stage");
    reset_code_a: assert property ((code_reg == CODE_RESET) == prot_reset)
        else $error("reset code and protection reset disagree");
    oc_abort_a: assert property (running && over |=> code_reg == CODE_NORMAL && lockout_reg)
        else $error("over-current did not abort");
    lockout_a: assert property (lockout_reg && start_req && !running
        |=> code_reg == CODE_NORMAL)
        else $error("restart taken during lockout");
    block_a: assert property (blocked |=> code_reg == CODE_NORMAL)
        else $error("sequencer ran while blocked");
    force_post_a: assert property (s_force_in_run |=> code_reg == CODE_POST)
        else $error("force-post did not reach post-fault");
    freeze_a: assert property (code_reg != CODE_NORMAL |-> energy_freeze && sim_active)
        else $error("energy counters not frozen");
    cold_trip_a: assert property (s_cold_trip |=> !breaker_trip_command)
        else $error("trip command passed in cold policy");
    hot_trip_a: assert property (ctrl_reg[CTRL_HOT] && prot_trip_request
        |=> breaker_trip_command)
        else $error("trip command lost in hot policy");
    stop_a: assert property (stop_req |=> code_reg == CODE_NORMAL && !energy_freeze)
        else $error("stop did not return to normal");
    busy_start_a: assert property (running && start_req
        |=> state_reg != S_RST_IN || $past(state_reg) == S_RST_IN)
        else $error("start restarted a running cycle");
endmodule
